// *** hdl/rds_consts.svh ***
/*
 constant definitions for the run-enable and dwell sequencer.
 assumes frequencies in 0.01 Hz units and times in 0.1 s units.
*/
`ifndef RDS_CONSTS_SVH
`define RDS_CONSTS_SVH
`define RDS_FN_RUN_ENABLE 8'h0D
`define RDS_FN_W 8
`define RDS_SEL_ALWAYS 1'b0
`define RDS_SEL_TERMINAL 1'b1
`define RDS_STOP_COAST 2'h0
`define RDS_STOP_QUICK 2'h1
`define RDS_STOP_QRESUME 2'h2
`define RDS_QSTOP_DEF 16'h0032
`define RDS_QSTOP_MAX 16'h1770
`define RDS_DWELL_F_DEF 16'h01F4
`define RDS_ACC_DWT_MAX 16'h0064
`define RDS_DEC_DWT_MAX 16'h0258
`define RDS_TICK_NS 100000000
`define RDS_CLK_NS 4
`endif

// *** hdl/rds_pkg.sv ***
/*
 types for the run-enable and dwell sequencer.
 assumes rds_consts.svh holds the numeric constants.
*/
package rds_pkg;
   typedef enum logic [2:0] {
      RDS_IDLE, RDS_ACC_DWELL, RDS_RUN, RDS_DEC_DWELL, RDS_STOPPING, RDS_QSTOP
   } rds_state_t;
endpackage

// *** hdl/rds_ramp.sv ***
/*
 frequency ramp: moves the output frequency toward a target by a step each
 time tick. assumes the step is precomputed from the ramp time by the caller.
*/
`timescale 1ns/1ps
module rds_ramp #(
   parameter int FW = 16
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic tick_in,
   input wire logic [FW-1:0] target_in,
   input wire logic [FW-1:0] step_in,
   output logic [FW-1:0] freq_out
);
   wire logic [FW:0] up_sum = {1'b0, freq_out} + {1'b0, step_in};
   wire logic up_over = up_sum > {1'b0, target_in};
   // widened so a target near full scale cannot wrap the compare
   wire logic dn_under = {1'b0, freq_out} < ({1'b0, target_in} + {1'b0, step_in});
   wire logic [FW-1:0] next_freq = (freq_out < target_in) ?
      (up_over ? target_in : up_sum[FW-1:0]) :
      (dn_under ? target_in : freq_out - step_in);
   // step of zero means instantaneous change
   wire logic [FW-1:0] jump = (step_in == '0) ? target_in : next_freq;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         freq_out <= '0;
      end else if (tick_in) begin
         freq_out <= jump;
      end
   end
endmodule

// *** hdl/rds_top.sv ***
/*
 run-enable gate and dwell sequencer for a motor drive.
 assumes terminals and commands are synchronous to clk_in; ramp steps are
 given per 0.1 s tick in 0.01 Hz units by the surrounding control.
*/
`timescale 1ns/1ps
`include "rds_consts.svh"
module rds_top #(
   parameter int NT = 5,
   parameter int FW = 16,
   parameter int TICK_CYC = `RDS_TICK_NS / `RDS_CLK_NS
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [NT-1:0] terminal_in,
   input wire logic [NT*8-1:0] input_terminal_function_in,
   input wire logic run_en_sel_in,
   input wire logic [1:0] stop_mode_in,
   input wire logic [15:0] qstop_time_in,
   input wire logic [15:0] qstop_step_in,
   input wire logic run_cmd_in,
   input wire logic [FW-1:0] target_freq_in,
   input wire logic [FW-1:0] acc_step_in,
   input wire logic [FW-1:0] dec_step_in,
   input wire logic [FW-1:0] acc_dwell_freq_in,
   input wire logic [15:0] acc_dwell_time_in,
   input wire logic [FW-1:0] dec_dwell_freq_in,
   input wire logic [15:0] dec_dwell_time_in,
   input wire logic ext_brake_in,
   output logic [FW-1:0] freq_ref_out,
   output logic output_enable_out,
   output logic terminal_gated_permit_out,
   output logic [2:0] state_out
);
   rds_pkg::rds_state_t state;
   logic [31:0] tick_cnt;
   logic [15:0] dwell_cnt;
   logic run_d;
   logic acc_done;
   logic [FW-1:0] ramp_target;
   logic [FW-1:0] ramp_step;
   wire logic [FW-1:0] freq;
   wire logic [NT-1:0] fn_hit;
   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_term
         assign fn_hit[g] = terminal_in[g] &&
            (input_terminal_function_in[g*`RDS_FN_W +: `RDS_FN_W] == `RDS_FN_RUN_ENABLE);
         term_grant_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
            fn_hit[g] |=> terminal_gated_permit_out)
            else $error("enabled terminal gives no permit");
      end
   endgenerate
   wire logic permit = (run_en_sel_in == `RDS_SEL_ALWAYS) ? 1'b1 : (|fn_hit);
   // tick marks one 0.1 s step of the ramp and of the dwell timers
   wire logic tick = (tick_cnt == 32'(TICK_CYC - 1));
   wire logic run_rise = run_cmd_in && !run_d;
   // out-of-range times saturate to the settable maximum
   wire logic [15:0] acc_dwt = (acc_dwell_time_in > `RDS_ACC_DWT_MAX) ?
      `RDS_ACC_DWT_MAX : acc_dwell_time_in;
   wire logic [15:0] dec_dwt = (dec_dwell_time_in > `RDS_DEC_DWT_MAX) ?
      `RDS_DEC_DWT_MAX : dec_dwell_time_in;
   wire logic [15:0] qst = (qstop_time_in > `RDS_QSTOP_MAX) ? `RDS_QSTOP_MAX : qstop_time_in;
   wire logic acc_dw_on = (acc_dwt != '0) && (acc_dwell_freq_in != '0) && !acc_done;
   wire logic dec_dw_on = (dec_dwt != '0) && (dec_dwell_freq_in != '0) && !ext_brake_in &&
      (freq > dec_dwell_freq_in);
   // zero quick-stop time means an immediate stop
   wire logic [FW-1:0] q_step = (qst == '0) ? '0 : qstop_step_in[FW-1:0];
   wire logic at_target = (freq == ramp_target);
   // coast is taken at once; both quick modes ramp down first
   wire logic drop = !permit && (stop_mode_in == `RDS_STOP_COAST);
   wire logic qdrop = !permit && (stop_mode_in != `RDS_STOP_COAST);
   rds_pkg::rds_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         rds_pkg::RDS_IDLE: begin
            if (run_cmd_in && permit && (run_rise || stop_mode_in != `RDS_STOP_QUICK ||
                  run_en_sel_in == `RDS_SEL_ALWAYS)) begin
               next_state = acc_dw_on ? rds_pkg::RDS_ACC_DWELL : rds_pkg::RDS_RUN;
            end
         end
         rds_pkg::RDS_ACC_DWELL: begin
            if (qdrop) begin
               next_state = rds_pkg::RDS_QSTOP;
            end else if (!run_cmd_in) begin
               next_state = rds_pkg::RDS_STOPPING;
            end else if (at_target && dwell_cnt >= acc_dwt) begin
               next_state = rds_pkg::RDS_RUN;
            end
         end
         rds_pkg::RDS_RUN: begin
            if (qdrop) begin
               next_state = rds_pkg::RDS_QSTOP;
            end else if (!run_cmd_in) begin
               next_state = dec_dw_on ? rds_pkg::RDS_DEC_DWELL : rds_pkg::RDS_STOPPING;
            end
         end
         rds_pkg::RDS_DEC_DWELL: begin
            if (qdrop) begin
               next_state = rds_pkg::RDS_QSTOP;
            end else if (at_target && dwell_cnt >= dec_dwt) begin
               next_state = rds_pkg::RDS_STOPPING;
            end
         end
         rds_pkg::RDS_STOPPING: begin
            if (qdrop) begin
               next_state = rds_pkg::RDS_QSTOP;
            end else if (freq == '0) begin
               next_state = rds_pkg::RDS_IDLE;
            end
         end
         rds_pkg::RDS_QSTOP: begin
            if (freq == '0) begin
               next_state = rds_pkg::RDS_IDLE;
            end
         end
         default: next_state = rds_pkg::RDS_IDLE;
      endcase
      if (drop && state != rds_pkg::RDS_IDLE) begin
         next_state = rds_pkg::RDS_IDLE;
      end
   end
   always_comb begin
      ramp_step = acc_step_in;
      ramp_target = '0;
      unique case (state)
         rds_pkg::RDS_IDLE: ramp_target = '0;
         rds_pkg::RDS_ACC_DWELL: ramp_target = acc_dwell_freq_in;
         rds_pkg::RDS_RUN: begin
            ramp_target = target_freq_in;
            ramp_step = (freq > target_freq_in) ? dec_step_in : acc_step_in;
         end
         rds_pkg::RDS_DEC_DWELL: begin
            ramp_target = dec_dwell_freq_in;
            ramp_step = dec_step_in;
         end
         rds_pkg::RDS_STOPPING: ramp_step = dec_step_in;
         rds_pkg::RDS_QSTOP: ramp_step = q_step;
         default: ramp_target = '0;
      endcase
   end
   rds_ramp #(.FW(FW)) u_ramp (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .target_in(ramp_target),
      .step_in(ramp_step),
      .freq_out(freq)
   );
   wire logic dwelling = (state == rds_pkg::RDS_ACC_DWELL) ||
      (state == rds_pkg::RDS_DEC_DWELL);
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick ? '0 : tick_cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= rds_pkg::RDS_IDLE;
         run_d <= 1'b0;
         dwell_cnt <= '0;
         acc_done <= 1'b0;
      end else begin
         state <= next_state;
         run_d <= run_cmd_in;
         // hold time counts only once the dwell frequency is reached
         if (next_state != state || !dwelling) begin
            dwell_cnt <= '0;
         end else if (tick && at_target && dwell_cnt != '1) begin
            dwell_cnt <= dwell_cnt + 16'h0001;
         end
         // a quick stop with run held keeps the flag, so the resumed run skips the dwell
         if (state == rds_pkg::RDS_IDLE && next_state != rds_pkg::RDS_IDLE) begin
            acc_done <= 1'b1;
         end else if (!run_cmd_in && next_state == rds_pkg::RDS_IDLE) begin
            acc_done <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         freq_ref_out <= '0;
         output_enable_out <= 1'b0;
         terminal_gated_permit_out <= 1'b0;
         state_out <= '0;
      end else begin
         freq_ref_out <= (next_state == rds_pkg::RDS_IDLE) ? '0 : freq;
         output_enable_out <= (next_state != rds_pkg::RDS_IDLE);
         terminal_gated_permit_out <= permit;
         state_out <= next_state;
      end
   end
   // checks sit on internal state so a failure points at the transition, except the enable, reference and permit checks, which read the registered outputs
   coast_block_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state != rds_pkg::RDS_IDLE && drop) |=> !output_enable_out)
      else $error("output not blocked on coast");
   idle_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state == rds_pkg::RDS_IDLE |-> (!output_enable_out && freq_ref_out == '0))
      else $error("output active while idle");
   no_run_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_IDLE && !permit) |=> state == rds_pkg::RDS_IDLE)
      else $error("run accepted without permit");
   refused_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_IDLE && !permit) |=> !output_enable_out)
      else $error("output enabled without permit");
   always_sel_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      run_en_sel_in == `RDS_SEL_ALWAYS |=> terminal_gated_permit_out)
      else $error("permit not granted");
   term_deny_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (run_en_sel_in == `RDS_SEL_TERMINAL && fn_hit == '0) |=> !terminal_gated_permit_out)
      else $error("permit without enabled terminal");
   qstop_entry_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_RUN && qdrop) |=> state == rds_pkg::RDS_QSTOP)
      else $error("quick stop not entered");
   stop_qdrop_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_STOPPING && qdrop) |=> state == rds_pkg::RDS_QSTOP)
      else $error("quick stop not taken while stopping");
   quick_restart_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_IDLE && stop_mode_in == `RDS_STOP_QUICK &&
      run_en_sel_in == `RDS_SEL_TERMINAL && run_d) |=> state == rds_pkg::RDS_IDLE)
      else $error("quick stop restarted without new run");
   qstop_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_QSTOP && stop_mode_in != `RDS_STOP_COAST && freq != '0)
      |=> state == rds_pkg::RDS_QSTOP)
      else $error("quick stop left before standstill");
   qstop_ramp_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_QSTOP && tick && freq != '0) |=> freq < $past(freq))
      else $error("quick stop not decelerating");
   resume_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_IDLE && permit && run_cmd_in &&
      stop_mode_in == `RDS_STOP_QRESUME) |=> state != rds_pkg::RDS_IDLE)
      else $error("resume not taken");
   acc_first_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_IDLE && run_cmd_in && run_en_sel_in == `RDS_SEL_ALWAYS &&
      !acc_done && acc_dwt != '0 && acc_dwell_freq_in != '0)
      |=> state == rds_pkg::RDS_ACC_DWELL)
      else $error("acc dwell not entered");
   acc_reach_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_ACC_DWELL && permit && run_cmd_in && freq != acc_dwell_freq_in)
      |=> state == rds_pkg::RDS_ACC_DWELL)
      else $error("acc dwell left before dwell frequency");
   acc_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_ACC_DWELL && permit && run_cmd_in && dwell_cnt < acc_dwt)
      |=> state == rds_pkg::RDS_ACC_DWELL)
      else $error("acc dwell left early");
   run_ramp_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_RUN && tick && freq < target_freq_in)
      |=> freq > $past(freq))
      else $error("run not accelerating");
   acc_cap_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state == rds_pkg::RDS_ACC_DWELL |-> dwell_cnt <= `RDS_ACC_DWT_MAX)
      else $error("acc dwell time over range");
   dec_entry_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_RUN && permit && !run_cmd_in && dec_dw_on)
      |=> state == rds_pkg::RDS_DEC_DWELL)
      else $error("dec dwell not entered");
   dec_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_DEC_DWELL && permit && dwell_cnt < dec_dwt)
      |=> state == rds_pkg::RDS_DEC_DWELL)
      else $error("dec dwell left early");
   stop_ramp_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_STOPPING && tick && freq != '0) |=> freq < $past(freq))
      else $error("stop not decelerating");
   stop_end_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_STOPPING && permit && freq == '0) |=> state == rds_pkg::RDS_IDLE)
      else $error("stop not finished at standstill");
   dec_cap_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state == rds_pkg::RDS_DEC_DWELL |-> dwell_cnt <= `RDS_DEC_DWT_MAX)
      else $error("dec dwell time over range");
   acc_skip_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_IDLE && acc_dwt == '0) |=> state != rds_pkg::RDS_ACC_DWELL)
      else $error("zero dwell not skipped");
   dec_skip_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_RUN && dec_dwell_freq_in == '0)
      |=> state != rds_pkg::RDS_DEC_DWELL)
      else $error("zero dec dwell not skipped");
   acc_once_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_IDLE && acc_done) |=> state != rds_pkg::RDS_ACC_DWELL)
      else $error("acc dwell repeated");
   dec_brake_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (state == rds_pkg::RDS_RUN && ext_brake_in) |=> state != rds_pkg::RDS_DEC_DWELL)
      else $error("dec dwell under brake control");
   dwell_abort_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (dwelling && qdrop) |=> state == rds_pkg::RDS_QSTOP)
      else $error("dwell not abandoned");
endmodule

// *** sim/rds_panel.sv ***
/*
 partner model: the contact bank and push buttons in front of the sequencer,
 standing in for the operator and the terminal wiring.
 assumes the bench changes its requests just after a falling clock edge.
*/
`timescale 1ns/1ps
module rds_panel #(
   parameter int NT = 5,
   parameter int EN_BIT = 2
) (
   input wire logic clk_in,
   input wire logic permit_in,
   input wire logic run_in,
   output logic [NT-1:0] terminal_out,
   output logic run_cmd_out
);
   logic [NT-1:0] spare = '0;
   // other contacts chatter every cycle so any leak of them into the permit shows up
   always @(negedge clk_in) begin
      spare <= ~spare;
   end
   assign terminal_out = (spare & ~(NT'(1) << EN_BIT)) | (NT'(permit_in) << EN_BIT);
   assign run_cmd_out = run_in;
endmodule

// *** sim/run_enable_and_dwell_sequencer_tb_top.sv ***
/*
 testbench for the run-enable gate and dwell sequencer.
 assumes rds_top with a short tick and the contact model rds_panel.
*/
`timescale 1ns/1ps
module run_enable_and_dwell_sequencer_tb_top;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic perm = 1'b0, run = 1'b0, sel = 1'b1, brake = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [15:0] target = 16'h0bb8, acc_dwt = 16'h0002, dec_dwf = 16'h01f4;
   logic [15:0] acc_dwf = 16'h01f4, dec_dwt = 16'h0002, qstep = 16'h03e8;
   logic [4:0] terminal;
   logic run_cmd, oe, permit;
   logic [15:0] freq;
   logic [2:0] state;
   logic [7:0] seen = 8'h00;
   int failures = 0;
   int compares = 0;
   always #2 clk_in = ~clk_in;
   always @(posedge clk_in) seen[state] <= 1'b1;
   rds_panel panel (.clk_in(clk_in), .permit_in(perm), .run_in(run),
      .terminal_out(terminal), .run_cmd_out(run_cmd));
   // a tick of 10 cycles keeps dwell and ramp times short
   rds_top #(.TICK_CYC(10)) DUT (.clk_in(clk_in), .nrst_in(nrst_in), .terminal_in(terminal),
      .input_terminal_function_in(40'h00_000d_0000), .run_en_sel_in(sel),
      .stop_mode_in(mode), .qstop_time_in(16'h0032), .qstop_step_in(qstep),
      .run_cmd_in(run_cmd), .target_freq_in(target), .acc_step_in(16'h00fa),
      .dec_step_in(16'h00fa), .acc_dwell_freq_in(acc_dwf), .acc_dwell_time_in(acc_dwt),
      .dec_dwell_freq_in(dec_dwf), .dec_dwell_time_in(dec_dwt), .ext_brake_in(brake),
      .freq_ref_out(freq), .output_enable_out(oe), .terminal_gated_permit_out(permit),
      .state_out(state));
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task step(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task wait_st(input logic [2:0] exp);
      for (int i = 0; i < 400 && state !== exp; i++) @(negedge clk_in);
      chk("state", {13'h0000, exp}, {13'h0000, state});
   endtask
   task wait_f(input logic [15:0] exp);
      for (int i = 0; i < 400 && freq !== exp; i++) @(negedge clk_in);
      chk("freq", exp, freq);
   endtask
   task results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // whole sequence needs under two thousand cycles
   initial begin
      #100000;
      failures++;
      results;
   end
   initial begin
      step(5);
      nrst_in = 1'b1;
      run = 1'b1;
      step(20);
      chk("state", 16'h0000, {13'h0000, state});
      chk("oe", 16'h0000, {15'h0000, oe});
      perm = 1'b1;
      wait_st(rds_pkg::RDS_ACC_DWELL);
      chk("permit", 16'h0001, {15'h0000, permit});
      wait_f(16'h01f4);
      chk("state", 16'h0001, {13'h0000, state});
      wait_st(rds_pkg::RDS_RUN);
      wait_f(16'h0bb8);
      // a reference dip must not trigger either dwell
      seen = 8'h00;
      target = 16'h03e8;
      step(150);
      target = 16'h0bb8;
      step(150);
      chk("dwell", 16'h0000, {14'h0000, seen[1], seen[3]});
      run = 1'b0;
      wait_st(rds_pkg::RDS_DEC_DWELL);
      wait_f(16'h01f4);
      chk("state", 16'h0003, {13'h0000, state});
      wait_st(rds_pkg::RDS_IDLE);
      acc_dwt = 16'h0000;
      dec_dwf = 16'h0000;
      seen = 8'h00;
      run = 1'b1;
      wait_st(rds_pkg::RDS_RUN);
      wait_f(16'h0bb8);
      run = 1'b0;
      wait_st(rds_pkg::RDS_IDLE);
      chk("dwell", 16'h0000, {14'h0000, seen[1], seen[3]});
      run = 1'b1;
      wait_st(rds_pkg::RDS_RUN);
      perm = 1'b0;
      step(3);
      chk("oe", 16'h0000, {15'h0000, oe});
      chk("state", 16'h0000, {13'h0000, state});
      run = 1'b0;
      mode = 2'h1;
      perm = 1'b1;
      step(2);
      run = 1'b1;
      wait_st(rds_pkg::RDS_RUN);
      wait_f(16'h0bb8);
      perm = 1'b0;
      wait_st(rds_pkg::RDS_QSTOP);
      step(5);
      chk("state", 16'h0005, {13'h0000, state});
      wait_st(rds_pkg::RDS_IDLE);
      perm = 1'b1;
      step(40);
      chk("state", 16'h0000, {13'h0000, state});
      run = 1'b0;
      step(2);
      run = 1'b1;
      wait_st(rds_pkg::RDS_RUN);
      mode = 2'h2;
      perm = 1'b0;
      wait_st(rds_pkg::RDS_QSTOP);
      wait_st(rds_pkg::RDS_IDLE);
      perm = 1'b1;
      wait_st(rds_pkg::RDS_RUN);
      wait_f(16'h0bb8);
      brake = 1'b1;
      dec_dwf = 16'h01f4;
      seen = 8'h00;
      run = 1'b0;
      wait_st(rds_pkg::RDS_IDLE);
      chk("dwell", 16'h0000, {15'h0000, seen[3]});
      brake = 1'b0;
      sel = 1'b0;
      perm = 1'b0;
      mode = 2'h0;
      acc_dwt = 16'h0002;
      run = 1'b1;
      wait_st(rds_pkg::RDS_ACC_DWELL);
      sel = 1'b1;
      step(3);
      chk("state", 16'h0000, {13'h0000, state});
      chk("permit", 16'h0000, {15'h0000, permit});
      run = 1'b0;
      mode = 2'h1;
      sel = 1'b0;
      step(2);
      run = 1'b1;
      wait_st(rds_pkg::RDS_ACC_DWELL);
      sel = 1'b1;
      wait_st(rds_pkg::RDS_QSTOP);
      wait_st(rds_pkg::RDS_IDLE);
      results;
   end
endmodule
